// ==== src/plld_defines.vh ====
// Register map, field positions and timing constants of the lock detector
`ifndef PLLD_DEFINES_VH
`define PLLD_DEFINES_VH
// Register offsets
`define PLLD_A_R_LO        10'h011
`define PLLD_A_R_HI        10'h012
`define PLLD_A_ACNT        10'h013
`define PLLD_A_B_LO        10'h014
`define PLLD_A_B_HI        10'h015
`define PLLD_A_PRESC       10'h016
`define PLLD_A_STAT_ABP    10'h017
`define PLLD_A_LDCFG       10'h018
`define PLLD_A_LDPIN       10'h01A
`define PLLD_A_REFERENCE_MONITOR_PIN      10'h01B
`define PLLD_A_PINCMP      10'h01D
`define PLLD_A_QTHR        10'h01E
`define PLLD_A_STATUS      10'h01F
`define PLLD_A_NDLY        10'h020
`define PLLD_A_RDLY        10'h021
`define PLLD_A_OEQL0       10'h0FC
`define PLLD_A_OEQL1       10'h0FD
// Reset values of the divider counters and qualified-lock threshold
`define PLLD_RST_R         14'h0001
`define PLLD_RST_B         13'h0003
`define PLLD_RST_QTHR      8'h10
// Field positions
`define PLLD_F_LDCNT       6:5
`define PLLD_F_WIN         4
`define PLLD_F_DLDOFF      3
`define PLLD_F_STATSEL     7:2
`define PLLD_F_ABP         1:0
`define PLLD_F_CMPEN       3
`define PLLD_F_DLYEN       3
`define PLLD_F_DLYCODE     2:0
// Prescaler codes: dual modulus P/(P+1), then fixed divide
`define PLLD_PS_DM2        3'h0
`define PLLD_PS_DM4        3'h1
`define PLLD_PS_DM8        3'h2
`define PLLD_PS_DM16       3'h3
`define PLLD_PS_DM32       3'h4
`define PLLD_PS_FD1        3'h5
`define PLLD_PS_FD2        3'h6
`define PLLD_PS_FD3        3'h7
// Pin multiplexer codes
`define PLLD_LD_DLD        6'h01
`define PLLD_LD_ALDN       6'h02
`define PLLD_LD_ALDP       6'h03
`define PLLD_LD_CS         6'h04
`define PLLD_PIN_DLD       6'h01
`define PLLD_PIN_CMP       6'h02
// Lock windows in clock cycles, high and low range
`define PLLD_LK_THR_HI     8'h04
`define PLLD_LK_THR_LO     8'h02
`define PLLD_UL_THR_HI     8'h08
`define PLLD_UL_THR_LO     8'h04
// Consecutive in-window edge pairs per counter code
`define PLLD_LDCNT_0       5'h05
`define PLLD_LDCNT_1       5'h10
`define PLLD_LDCNT_2       5'h02
`define PLLD_LDCNT_3       5'h03
// Delay cell: total range in ns, one clock per code step
`define PLLD_DLY_RANGE_NS  1
`define PLLD_CLK_NS        10
`define PLLD_DLY_STEP_CYC  1
`endif

// ==== src/plld_divdly.v ====
// Edge divider followed by a programmable delay cell
`timescale 1ns/1ps
`default_nettype none
module plld_divdly (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Edge stream and divide ratio
  input  wire        edge_i,
  input  wire [18:0] ratio_i,
  // Delay cell control
  input  wire        dly_en_i,
  input  wire [2:0]  dly_code_i,
  // Divided, delayed pulse
  output reg         pulse_o
);
  reg  [18:0] cnt_q;
  reg  [7:0]  sr_q;
  wire        tick;
  wire [18:0] last;

  // Ratios of zero and one both divide by one
  assign last = (ratio_i > 19'h00001) ? ratio_i - 19'h00001 : 19'h00000;
  assign tick = edge_i && (cnt_q >= last);

  // Edge counter
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 19'h00000;
    end else if (ce_i && edge_i) begin
      cnt_q <= tick ? 19'h00000 : cnt_q + 19'h00001;
    end
  end

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sr_q    <= 8'h00;
      pulse_o <= 1'b0;
    end else if (ce_i) begin
      sr_q    <= {sr_q[6:0], tick};
      pulse_o <= dly_en_i ? sr_q[dly_code_i] : tick;
    end
  end
endmodule
`default_nettype wire

// ==== src/plld_top.v ====
// Lock detector with divider ratios, pin muxes and qualified-lock gating
`timescale 1ns/1ps
`default_nettype none
`include "plld_defines.vh"
module plld_top (
  // Clock, reset, enable
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Reference and prescaler edge inputs (asynchronous)
  input  wire        ref_clk_i,
  input  wire        vco_clk_i,
  // Register write and read port
  input  wire [9:0]  cfg_addr_i,
  input  wire [7:0]  cfg_wdata_i,
  input  wire        cfg_we_i,
  output reg  [7:0]  cfg_rdata_o,
  // Lock pin (push-pull for DLD, open drain or current source)
  output reg         lock_pin_o,
  output reg         lock_pin_oe_o,
  output reg         lock_src_o,
  // Multiplexed status pins
  output reg         status_pin_o,
  output reg         reference_monitor_pin_o,
  // Clock output enables
  output reg  [15:0] clk_out_en_o
);
  // Configuration registers
  reg [13:0] r_cnt_q;
  reg [5:0]  a_cnt_q;
  reg [12:0] b_cnt_q;
  reg [2:0]  presc_q;
  reg [7:0]  stat_abp_q, ldcfg_q, ldpin_q, reference_monitor_pin_q, pincmp_q, qthr_q;
  reg [7:0]  ndly_q, rdly_q, oeql0_q, oeql1_q;
  // Synchronisers
  reg [2:0]  ref_s_q, vco_s_q;
  // Detector state
  reg        err_act_q, err_ref_q, digital_lock_flag_q, qualified_lock_q;
  reg [7:0]  err_cnt_q;
  reg [4:0]  consec_q;
  reg [15:0] q_cnt_q;
  // Combinational
  reg [5:0]  p_val;
  reg        fixed_divide_mode;
  reg [18:0] n_ratio;
  reg [7:0]  lk_thr, ul_thr, diff;
  reg [4:0]  need;
  reg        done;
  wire       ref_edge, vco_edge, rp, np, comp_out;

  // Two-stage synchronisers, third stage for edge detection
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_s_q <= 3'h0;
      vco_s_q <= 3'h0;
    end else if (ce_i) begin
      ref_s_q <= {ref_s_q[1:0], ref_clk_i};
      vco_s_q <= {vco_s_q[1:0], vco_clk_i};
    end
  end
  assign ref_edge = ref_s_q[1] & ~ref_s_q[2];
  assign vco_edge = vco_s_q[1] & ~vco_s_q[2];

  // Register writes
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      r_cnt_q    <= `PLLD_RST_R;
      a_cnt_q    <= 6'h00;
      b_cnt_q    <= `PLLD_RST_B;
      presc_q    <= `PLLD_PS_FD1;
      stat_abp_q <= 8'h00;
      ldcfg_q    <= 8'h00;
      ldpin_q    <= 8'h00;
      reference_monitor_pin_q   <= 8'h00;
      pincmp_q   <= 8'h00;
      qthr_q     <= `PLLD_RST_QTHR;
      ndly_q     <= 8'h00;
      rdly_q     <= 8'h00;
      oeql0_q    <= 8'h00;
      oeql1_q    <= 8'h00;
    end else if (ce_i && cfg_we_i) begin
      case (cfg_addr_i)
        `PLLD_A_R_LO:     r_cnt_q[7:0]  <= cfg_wdata_i;
        `PLLD_A_R_HI:     r_cnt_q[13:8] <= cfg_wdata_i[5:0];
        `PLLD_A_ACNT:     a_cnt_q       <= cfg_wdata_i[5:0];
        `PLLD_A_B_LO:     b_cnt_q[7:0]  <= cfg_wdata_i;
        `PLLD_A_B_HI:     b_cnt_q[12:8] <= cfg_wdata_i[4:0];
        `PLLD_A_PRESC:    presc_q       <= cfg_wdata_i[2:0];
        `PLLD_A_STAT_ABP: stat_abp_q    <= cfg_wdata_i;
        `PLLD_A_LDCFG:    ldcfg_q       <= cfg_wdata_i;
        `PLLD_A_LDPIN:    ldpin_q       <= {2'h0, cfg_wdata_i[5:0]};
        `PLLD_A_REFERENCE_MONITOR_PIN:   reference_monitor_pin_q      <= {3'h0, cfg_wdata_i[4:0]};
        `PLLD_A_PINCMP:   pincmp_q      <= cfg_wdata_i;
        `PLLD_A_QTHR:     qthr_q        <= cfg_wdata_i;
        `PLLD_A_NDLY:     ndly_q        <= {4'h0, cfg_wdata_i[3:0]};
        `PLLD_A_RDLY:     rdly_q        <= {4'h0, cfg_wdata_i[3:0]};
        `PLLD_A_OEQL0:    oeql0_q       <= cfg_wdata_i;
        `PLLD_A_OEQL1:    oeql1_q       <= cfg_wdata_i;
        default: ;
      endcase
    end
  end

  // Prescaler value and mode
  always @* begin
    case (presc_q)
      `PLLD_PS_DM2:  p_val = 6'h02;
      `PLLD_PS_DM4:  p_val = 6'h04;
      `PLLD_PS_DM8:  p_val = 6'h08;
      `PLLD_PS_DM16: p_val = 6'h10;
      `PLLD_PS_DM32: p_val = 6'h20;
      `PLLD_PS_FD1:  p_val = 6'h01;
      `PLLD_PS_FD2:  p_val = 6'h02;
      default:       p_val = 6'h03;
    endcase
    // Codes above the last dual-modulus one are fixed divide
    fixed_divide_mode = (presc_q > `PLLD_PS_DM32);
    // dual modulus N = P*B + A unless B is one, which gives N = P
    n_ratio = p_val * b_cnt_q + {13'h0000, a_cnt_q};
    if (fixed_divide_mode) begin
      n_ratio = p_val * b_cnt_q;
    end
    if (b_cnt_q == 13'h0001) begin
      n_ratio = {13'h0000, p_val};
    end
  end

  plld_divdly u_rdiv (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .edge_i     (ref_edge),
    .ratio_i    ({5'h00, r_cnt_q}),
    .dly_en_i   (rdly_q[`PLLD_F_DLYEN]),
    .dly_code_i (rdly_q[`PLLD_F_DLYCODE]),
    .pulse_o    (rp)
  );

  plld_divdly u_ndiv (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .edge_i     (vco_edge),
    .ratio_i    (n_ratio),
    .dly_en_i   (ndly_q[`PLLD_F_DLYEN]),
    .dly_code_i (ndly_q[`PLLD_F_DLYCODE]),
    .pulse_o    (np)
  );

  // windows from range bit, antibacklash, counter code
  always @* begin
    lk_thr = (ldcfg_q[`PLLD_F_WIN] ? `PLLD_LK_THR_LO : `PLLD_LK_THR_HI)
             + {6'h00, stat_abp_q[`PLLD_F_ABP]};
    ul_thr = (ldcfg_q[`PLLD_F_WIN] ? `PLLD_UL_THR_LO : `PLLD_UL_THR_HI)
             + {6'h00, stat_abp_q[`PLLD_F_ABP]};
    case (ldcfg_q[`PLLD_F_LDCNT])
      2'h0:    need = `PLLD_LDCNT_0;
      2'h1:    need = `PLLD_LDCNT_1;
      2'h2:    need = `PLLD_LDCNT_2;
      default: need = `PLLD_LDCNT_3;
    endcase
    // Pairing of reference and feedback edges
    done = 1'b0;
    diff = 8'h00;
    if (rp && np) begin
      done = 1'b1;
    end else if ((rp || np) && err_act_q) begin
      done = 1'b1;
      diff = (rp == err_ref_q) ? 8'hFF : err_cnt_q;
    end
  end

  // Phase error timing and digital lock
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      err_act_q           <= 1'b0;
      err_ref_q           <= 1'b0;
      err_cnt_q           <= 8'h00;
      consec_q            <= 5'h00;
      digital_lock_flag_q <= 1'b0;
    end else if (ce_i) begin
      if ((rp || np) && !(rp && np) && (!err_act_q || rp == err_ref_q)) begin
        err_act_q <= 1'b1;
        err_ref_q <= rp;
        err_cnt_q <= 8'h01;
      end else if (done) begin
        err_act_q <= 1'b0;
        err_cnt_q <= 8'h00;
      end else if (err_act_q && err_cnt_q != 8'hFF) begin
        err_cnt_q <= err_cnt_q + 8'h01;
      end
      if (ldcfg_q[`PLLD_F_DLDOFF]) begin
        consec_q            <= 5'h00;
        digital_lock_flag_q <= 1'b0;
      end else if ((done && diff > ul_thr) ||
                   (err_act_q && err_cnt_q > ul_thr)) begin
        consec_q            <= 5'h00;
        digital_lock_flag_q <= 1'b0;
      end else if (done && diff < lk_thr) begin
        if (consec_q + 5'h01 >= need) begin
          digital_lock_flag_q <= 1'b1;
          consec_q            <= need;
        end else begin
          consec_q <= consec_q + 5'h01;
        end
      end else if (done) begin
        consec_q <= 5'h00;
      end
    end
  end

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q_cnt_q          <= 16'h0000;
      qualified_lock_q <= 1'b0;
    end else if (ce_i) begin
      if (!digital_lock_flag_q) begin
        q_cnt_q          <= 16'h0000;
        qualified_lock_q <= 1'b0;
      end else if (q_cnt_q >= {qthr_q, 8'h00}) begin
        qualified_lock_q <= 1'b1;
      end else begin
        q_cnt_q <= q_cnt_q + 16'h0001;
      end
    end
  end

  // Comparator sees high when disabled
  assign comp_out = ~pincmp_q[`PLLD_F_CMPEN] |
                    (qualified_lock_q & (ldpin_q[5:0] == `PLLD_LD_CS));

  // Pin drivers, enables and read data
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_pin_o              <= 1'b0;
      lock_pin_oe_o           <= 1'b0;
      lock_src_o              <= 1'b0;
      status_pin_o            <= 1'b0;
      reference_monitor_pin_o <= 1'b0;
      clk_out_en_o            <= 16'hFFFF;
      cfg_rdata_o             <= 8'h00;
    end else if (ce_i) begin
      lock_src_o <= 1'b0;
      case (ldpin_q[5:0])
        `PLLD_LD_DLD: begin
          lock_pin_oe_o <= 1'b1;
          lock_pin_o    <= digital_lock_flag_q;
        end
        `PLLD_LD_ALDN: begin
          lock_pin_oe_o <= err_act_q;
          lock_pin_o    <= 1'b0;
        end
        `PLLD_LD_ALDP: begin
          lock_pin_oe_o <= err_act_q;
          lock_pin_o    <= 1'b1;
        end
        `PLLD_LD_CS: begin
          lock_src_o    <= digital_lock_flag_q;
          lock_pin_oe_o <= ~digital_lock_flag_q;
          lock_pin_o    <= 1'b0;
        end
        default: begin
          lock_pin_oe_o <= 1'b1;
          lock_pin_o    <= 1'b0;
        end
      endcase
      status_pin_o <=
        (stat_abp_q[`PLLD_F_STATSEL] == `PLLD_PIN_DLD) ? digital_lock_flag_q :
        (stat_abp_q[`PLLD_F_STATSEL] == `PLLD_PIN_CMP) ? comp_out : 1'b0;
      reference_monitor_pin_o <=
        (reference_monitor_pin_q[5:0] == `PLLD_PIN_DLD) ? digital_lock_flag_q :
        (reference_monitor_pin_q[5:0] == `PLLD_PIN_CMP) ? comp_out : 1'b0;
      clk_out_en_o <= ~{oeql1_q, oeql0_q} | {16{qualified_lock_q}};
      case (cfg_addr_i)
        `PLLD_A_R_LO:     cfg_rdata_o <= r_cnt_q[7:0];
        `PLLD_A_R_HI:     cfg_rdata_o <= {2'h0, r_cnt_q[13:8]};
        `PLLD_A_ACNT:     cfg_rdata_o <= {2'h0, a_cnt_q};
        `PLLD_A_B_LO:     cfg_rdata_o <= b_cnt_q[7:0];
        `PLLD_A_B_HI:     cfg_rdata_o <= {3'h0, b_cnt_q[12:8]};
        `PLLD_A_PRESC:    cfg_rdata_o <= {5'h00, presc_q};
        `PLLD_A_STAT_ABP: cfg_rdata_o <= stat_abp_q;
        `PLLD_A_LDCFG:    cfg_rdata_o <= ldcfg_q;
        `PLLD_A_LDPIN:    cfg_rdata_o <= ldpin_q;
        `PLLD_A_REFERENCE_MONITOR_PIN:   cfg_rdata_o <= reference_monitor_pin_q;
        `PLLD_A_PINCMP:   cfg_rdata_o <= pincmp_q;
        `PLLD_A_QTHR:     cfg_rdata_o <= qthr_q;
        `PLLD_A_STATUS:   cfg_rdata_o <= {4'h0, comp_out, err_act_q,
                                          qualified_lock_q,
                                          digital_lock_flag_q};
        `PLLD_A_NDLY:     cfg_rdata_o <= ndly_q;
        `PLLD_A_RDLY:     cfg_rdata_o <= rdly_q;
        `PLLD_A_OEQL0:    cfg_rdata_o <= oeql0_q;
        `PLLD_A_OEQL1:    cfg_rdata_o <= oeql1_q;
        default:          cfg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== dv/plld_clk_src.sv ====
// Reference and feedback edge sources with per-stream phase lag
`timescale 1ns/1ps
`default_nettype none
module plld_clk_src (
  // Clock
  input  wire logic       mclk_i,
  // Period and lags in clock cycles
  input  wire logic [7:0] per_i,
  input  wire logic [7:0] lag_r_i,
  input  wire logic [7:0] lag_v_i,
  // Edge streams
  output var  logic       ref_o,
  output var  logic       vco_o
);
  logic [7:0] ph_q = 8'h00;
  logic [7:0] lr_q = 8'h00;
  logic [7:0] lv_q = 8'h00;
  // High four cycles from the lagged phase, wide enough to sync
  function automatic logic hi(input logic [7:0] p, input logic [7:0] l);
    hi = (((p >= l) ? p - l : p + per_i - l) < 8'h04);
  endfunction
  initial {ref_o, vco_o} = 2'b00;
  // Free-running phase, edges launched off the falling edge; lags are
  // taken only at the period boundary so a change never adds an edge
  always @(negedge mclk_i) begin
    ph_q <= (ph_q + 8'h01 >= per_i) ? 8'h00 : ph_q + 8'h01;
    if (ph_q + 8'h01 >= per_i) begin
      lr_q <= lag_r_i;
      lv_q <= lag_v_i;
    end
    ref_o <= hi(ph_q, lr_q);
    vco_o <= hi(ph_q, lv_q);
  end
endmodule
`default_nettype wire

// ==== dv/plld_checker.sv ====
// Port-level assertions of the lock detector
`timescale 1ns/1ps
`default_nettype none
`include "plld_defines.vh"
module plld_checker (
  // Clock and control
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Edge streams
  input wire logic        ref_clk_i,
  input wire logic        vco_clk_i,
  // Register port
  input wire logic [9:0]  cfg_addr_i,
  input wire logic [7:0]  cfg_wdata_i,
  input wire logic        cfg_we_i,
  input wire logic [7:0]  cfg_rdata_o,
  // Pins and enables
  input wire logic        lock_pin_o,
  input wire logic        lock_pin_oe_o,
  input wire logic        lock_src_o,
  input wire logic        status_pin_o,
  input wire logic        reference_monitor_pin_o,
  input wire logic [15:0] clk_out_en_o
);
  logic [5:0]  ld_q, st_q;
  logic [15:0] sel_q, run_q;
  logic [7:0]  thr_q;
  logic [2:0]  wr_q;
  logic        cmp_q, quiet, qmode;
  // Setup settled: no write this cycle or the three before
  assign quiet = wr_q == 3'h0 && !cfg_we_i;
  assign qmode = quiet && ld_q == `PLLD_LD_CS && cmp_q
                 && st_q == `PLLD_PIN_CMP;
  // Shadow of pin setup and run length of sourced lock
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {ld_q, st_q, cmp_q, wr_q} <= 16'h0000;
      {sel_q, run_q} <= 32'h0000_0000;
      thr_q <= `PLLD_RST_QTHR;
    end else if (ce_i) begin
      wr_q <= {wr_q[1:0], cfg_we_i};
      run_q <= lock_src_o ? run_q + {15'h0000, run_q != 16'hFFFF} : 16'h0000;
      if (cfg_we_i) begin
        case (cfg_addr_i)
          `PLLD_A_LDPIN:    ld_q <= cfg_wdata_i[5:0];
          `PLLD_A_STAT_ABP: st_q <= cfg_wdata_i[7:2];
          `PLLD_A_PINCMP:   cmp_q <= cfg_wdata_i[3];
          `PLLD_A_QTHR:     thr_q <= cfg_wdata_i;
          `PLLD_A_OEQL0:    sel_q[7:0] <= cfg_wdata_i;
          `PLLD_A_OEQL1:    sel_q[15:8] <= cfg_wdata_i;
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  unmapped_zero_a:
    assert property (ce_i && cfg_addr_i == 10'h000 |=> cfg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  sel_readback_a:
    assert property (ce_i && cfg_we_i && cfg_addr_i == `PLLD_A_OEQL0 ##1
      ce_i && !cfg_we_i && cfg_addr_i == `PLLD_A_OEQL0 |=>
      cfg_rdata_o == $past(cfg_wdata_i, 2))
    else $error("enable select readback wrong");
  lock_mux_same_a:
    assert property (quiet && ld_q == `PLLD_LD_DLD && st_q == `PLLD_PIN_DLD
      |-> status_pin_o == lock_pin_o)
    else $error("status pin differs from lock pin");
  pulldown_low_a:
    assert property (quiet && ld_q == `PLLD_LD_ALDN |-> !lock_pin_o)
    else $error("pull-down mode drives high");
  pullup_high_a:
    assert property (quiet && ld_q == `PLLD_LD_ALDP |-> lock_pin_o)
    else $error("pull-up mode drives low");
  cs_ground_a:
    assert property (quiet && ld_q == `PLLD_LD_CS && !lock_src_o
      |-> lock_pin_oe_o && !lock_pin_o)
    else $error("pin not grounded without lock");
  out_gate_a:
    assert property (qmode |-> clk_out_en_o == (~sel_q | {16{status_pin_o}}))
    else $error("output enable gating wrong");
  qual_charge_a:
    assert property (qmode && $rose(status_pin_o)
      |-> run_q + 16'h0002 >= {thr_q, 8'h00})
    else $error("qualified lock rose too early");
  lock_seen_c: cover property (quiet && ld_q == `PLLD_LD_DLD && $rose(lock_pin_o));
  qual_rise_c: cover property (qmode && $rose(status_pin_o));
  gate_off_c: cover property (qmode && clk_out_en_o != 16'hFFFF);
endmodule
bind plld_top plld_checker i_plld_checker (
  .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .ref_clk_i(ref_clk_i),
  .vco_clk_i(vco_clk_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
  .cfg_we_i(cfg_we_i), .cfg_rdata_o(cfg_rdata_o), .lock_pin_o(lock_pin_o),
  .lock_pin_oe_o(lock_pin_oe_o), .lock_src_o(lock_src_o),
  .status_pin_o(status_pin_o), .clk_out_en_o(clk_out_en_o),
  .reference_monitor_pin_o(reference_monitor_pin_o));
`default_nettype wire

// ==== dv/pll_lock_detect_bench.sv ====
// Self-checking bench of the lock detector
`timescale 1ns/1ps
`default_nettype none
`include "plld_defines.vh"
module pll_lock_detect_bench;
  logic        mclk_i, rst_i, ce, we, rclk, vclk, lk, lk_oe, src, stp, rmp;
  logic [9:0]  addr;
  logic [7:0]  wdata, rdata, lag_r, lag_v;
  logic [15:0] en, sel;
  int          n_mismatch, n_tests, k, t;
  int          need [4] = '{5, 16, 2, 3};
  logic [7:0]  ps [4] = '{8'h00, 8'h05, 8'h07, 8'h05};
  logic [7:0]  bc [4] = '{8'h01, 8'h03, 8'h01, 8'h01};
  logic [7:0]  ac [4] = '{8'h00, 8'h00, 8'h00, 8'h05};
  logic [7:0]  wcf [3] = '{8'h10, 8'h10, 8'h00};
  logic [7:0]  wst [3] = '{8'h04, 8'h07, 8'h04};
  logic [7:0]  wlg [3] = '{8'h03, 8'h04, 8'h03};
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  plld_top i_plld_top (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
    .ref_clk_i(rclk), .vco_clk_i(vclk), .cfg_addr_i(addr),
    .cfg_wdata_i(wdata), .cfg_we_i(we), .cfg_rdata_o(rdata),
    .lock_pin_o(lk), .lock_pin_oe_o(lk_oe), .lock_src_o(src),
    .status_pin_o(stp), .reference_monitor_pin_o(rmp), .clk_out_en_o(en));
  // Period 40 stays above every unlock window
  plld_clk_src i_plld_clk_src (.mclk_i(mclk_i), .per_i(8'h28),
    .lag_r_i(lag_r), .lag_v_i(lag_v), .ref_o(rclk), .vco_o(vclk));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge mclk_i);
    we = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    addr = a;
    @(negedge mclk_i);
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  // Bounded wait for the lock pin; a must-reach miss ends the run
  task automatic wait_lk(input logic v, input int b, input logic m);
    for (t = 0; t < b && lk !== v; t++) begin
      @(negedge mclk_i);
    end
    if (m && lk !== v) begin
      chk({15'h0000, lk}, {15'h0000, v});
      stop_test();
    end
  endtask
  task automatic unlk();
    lag_r <= 8'h00;
    lag_v <= 8'h14;
    @(negedge mclk_i);
    wait_lk(1'b0, 200, 1'b1);
  endtask
  initial begin
    k = $urandom(32'hF50B);
    {rst_i, ce, we, addr, wdata, lag_r, lag_v} = 37'h18_0000_0000;
    n_mismatch = 0;
    n_tests = 0;
    repeat (12) @(negedge mclk_i);
    chk(en, 16'hFFFF);
    rst_i = 1'b0;
    rd(`PLLD_A_R_LO, 8'h01);
    rd(`PLLD_A_B_LO, 8'h03);
    rd(`PLLD_A_PRESC, 8'h05);
    rd(10'h000, 8'h00);
    sel = 16'($urandom);
    wr(`PLLD_A_OEQL0, sel[7:0]);
    rd(`PLLD_A_OEQL0, sel[7:0]);
    wr(`PLLD_A_OEQL1, sel[15:8]);
    rd(`PLLD_A_OEQL1, sel[15:8]);
    // Writes are refused while the clock enable is low
    ce = 1'b0;
    wr(`PLLD_A_OEQL0, ~sel[7:0]);
    ce = 1'b1;
    rd(`PLLD_A_OEQL0, sel[7:0]);
    wr(`PLLD_A_LDPIN, 8'h01);
    wr(`PLLD_A_STAT_ABP, 8'h04);
    wr(`PLLD_A_REFERENCE_MONITOR_PIN, 8'h01);
    // Divider settings against equal-rate edges; only ratio one locks
    // 2/3 mode only at a slow edge rate, ratios 7 and 11 unused
    for (k = 0; k < 4; k++) begin
      wr(`PLLD_A_PRESC, ps[k]);
      wr(`PLLD_A_B_LO, bc[k]);
      wr(`PLLD_A_ACNT, ac[k]);
      wait_lk(1'b1, 400, 1'b0);
      chk({15'h0000, lk}, {15'h0000, k == 3});
    end
    repeat (3) @(negedge mclk_i);
    chk({13'h0000, lk, stp, rmp}, 16'h0007);
    // Inside the band lock holds, beyond it drops, no relock in band
    lag_v <= 8'h06;
    repeat (200) @(negedge mclk_i);
    chk({15'h0000, lk}, 16'h0001);
    lag_v <= 8'h14;
    wait_lk(1'b0, 60, 1'b1);
    lag_v <= 8'h06;
    wait_lk(1'b1, 400, 1'b0);
    chk({15'h0000, lk}, 16'h0000);
    // Consecutive in-window pairs needed per counter code
    for (k = 0; k < 4; k++) begin
      wr(`PLLD_A_LDCFG, {1'b0, k[1:0], 5'h00});
      unlk();
      lag_v <= 8'($urandom_range(3));
      wait_lk(1'b1, (need[k] + 2) * 40, 1'b1);
      chk({15'h0000, t >= (need[k] - 2) * 40}, 16'h0001);
    end
    // Window range bit and antibacklash widening
    for (k = 0; k < 3; k++) begin
      unlk();
      wr(`PLLD_A_LDCFG, wcf[k]);
      wr(`PLLD_A_STAT_ABP, wst[k]);
      lag_v <= wlg[k];
      wait_lk(1'b1, 400, 1'b0);
      chk({15'h0000, lk}, {15'h0000, k != 0});
    end
    // Feedback delay of eight cycles cancels an eight-cycle lead
    unlk();
    lag_r <= 8'h08;
    lag_v <= 8'h00;
    wait_lk(1'b1, 400, 1'b0);
    chk({15'h0000, lk}, 16'h0000);
    wr(`PLLD_A_NDLY, 8'h0F);
    wait_lk(1'b1, 400, 1'b1);
    chk({15'h0000, lk}, 16'h0001);
    wr(`PLLD_A_NDLY, 8'h00);
    unlk();
    // Current-source mode with comparator on the status pin
    wr(`PLLD_A_LDPIN, 8'h04);
    wr(`PLLD_A_PINCMP, 8'h08);
    wr(`PLLD_A_QTHR, 8'h01);
    wr(`PLLD_A_STAT_ABP, 8'h08);
    repeat (5) @(negedge mclk_i);
    chk(en, ~sel);
    lag_v <= 8'h00;
    for (t = 0; t < 900 && en !== 16'hFFFF; t++) begin
      @(negedge mclk_i);
    end
    chk(en, 16'hFFFF);
    chk({15'h0000, t > 256}, 16'h0001);
    chk({14'h0000, stp, src}, 16'h0003);
    lag_v <= 8'h14;
    repeat (60) @(negedge mclk_i);
    chk(en, ~sel);
    // Pulse modes while the phase error persists
    wr(`PLLD_A_LDPIN, 8'h02);
    repeat (100) @(negedge mclk_i);
    chk({15'h0000, lk}, 16'h0000);
    wr(`PLLD_A_LDPIN, 8'h03);
    repeat (100) @(negedge mclk_i);
    chk({15'h0000, lk}, 16'h0001);
    stop_test();
  end
endmodule
`default_nettype wire
